// >>> logic/codec_pkg.sv
// constants shared by both ends of the codec serial sample link
// assumes a 20 MHz host clock and a master clock made from it by division
package codec_pkg;
    // word sizes and bit order
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] COMP_BITS = 5'h08;
    localparam logic [4:0] LIN_BITS = 5'h10;
    localparam logic [3:0] MSB_IDX = 4'hf;
    // volume attenuation field inside a linear receive word
    localparam int VOL_LSB = 0;
    localparam int VOL_W = 3;
    localparam logic [2:0] VOL_MAX = 3'h0;
    // host clock and framing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_PER_MCLK = 2;
    localparam int MCLK_PER_FRAME = 144;
    localparam int FRAME_CLKS = MCLK_PER_FRAME * CLK_PER_MCLK;
    localparam int PHASE_W = 9;
    localparam logic [8:0] PHASE_LAST = 9'(FRAME_CLKS - 1);
    localparam logic [8:0] PHASE_FIRST = 9'h000;
    // variable rate bit clock: 16 host clocks a bit, high for the first half
    localparam logic [3:0] VDR_HIGH_END = 4'h8;
    localparam logic [3:0] VDR_SAMPLE = 4'hf;
    // frame period measurement
    localparam int PERIOD_W = 8;
    localparam logic [7:0] PERIOD_MAX = 8'hff;
    // transmit sequencer states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_HOLD = 2'b10
    } tx_state_t;
    // fifo
    localparam int FIFO_DEPTH = 4;
endpackage

// >>> logic/codec_link_if.sv
// link between the codec device end and its controlling host end
// assumes pull-ups on the serial output and the slot indicator lines
`timescale 1ns/1ps
interface codec_link_if;
    logic mclk;
    logic tx_frame_sync;
    logic rx_frame_sync;
    logic tx_bit_clock;
    logic rx_bit_clock;
    logic rx_serial;
    logic tx_serial_o;
    logic tx_serial_oe;
    logic slot_o;
    logic slot_oe;
    logic tx_serial;
    logic tx_slot_indicator_n;

    // line levels worked out from the enables, pulled high when released
    assign tx_serial = tx_serial_oe ? tx_serial_o : 1'b1;
    assign tx_slot_indicator_n = slot_oe ? slot_o : 1'b1;

    modport device (
        input mclk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock, rx_serial,
        output tx_serial_o, tx_serial_oe, slot_o, slot_oe
    );
    modport host (
        output mclk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock, rx_serial,
        input tx_serial, tx_slot_indicator_n
    );
endinterface

// >>> logic/codec_device.sv
// codec device end of the serial sample link, clocked by the master clock
// assumes syncs, bit clocks and receive data come from the host's clock domain
//
// Operation
// - most significant bit goes in first slot
// - least significant bit fills the final slot
// - eight slots companded, sixteen slots linear
// - host keeps 144 master clocks per frame
// - sample rate follows frame sync, up to 24 kHz
// - fixed rate: bits launch on master clock rises
// - fixed rate: output released after last slot
// - fixed rate: slot indicator low during the slots
// - variable rate: first bit on sync rise
// - variable rate: later bits on bit clock rises
// - variable rate: output released on sync fall
// - linear receive word carries volume attenuation
`timescale 1ns/1ps
module codec_device (
    codec_link_if.device link,
    input wire logic nrst,
    input wire logic [15:0] tx_sample,
    input wire logic linear_mode,
    input wire logic fixed_rate_mode,
    output logic [15:0] rx_sample,
    output logic rx_sample_valid,
    output logic [2:0] volume_attenuation_field,
    output logic frame_strobe,
    output logic [7:0] frame_period
);
    // link inputs: 0 tx sync, 1 rx sync, 2 tx bit clock, 3 rx bit clock, 4 serial in
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [3:0] prev_reg;
    codec_pkg::tx_state_t tx_state_reg;
    codec_pkg::tx_state_t tx_state_next;
    logic [15:0] tx_shift_reg;
    logic [15:0] tx_shift_next;
    logic [4:0] tx_cnt_reg;
    logic [4:0] tx_cnt_next;
    logic tx_oe_reg;
    logic slot_oe_reg;
    logic [15:0] rx_shift_reg;
    logic [4:0] rx_cnt_reg;
    logic rx_active_reg;
    logic [15:0] rx_sample_reg;
    logic rx_valid_reg;
    logic [2:0] volume_reg;
    logic [7:0] period_cnt_reg;
    logic [7:0] period_reg;
    logic strobe_reg;

    // edge detection on the second synchroniser stage only
    wire tx_fs_rise = sync2_reg[0] & ~prev_reg[0];
    wire tx_fs_fall = ~sync2_reg[0] & prev_reg[0];
    wire rx_fs_rise = sync2_reg[1] & ~prev_reg[1];
    wire rx_fs_fall = ~sync2_reg[1] & prev_reg[1];
    wire tx_bclk_rise = sync2_reg[2] & ~prev_reg[2];
    wire rx_bclk_fall = ~sync2_reg[3] & prev_reg[3];
    wire serial_in = sync2_reg[4];

    // word length and last slot index
    wire [4:0] word_bits = linear_mode ? codec_pkg::LIN_BITS : codec_pkg::COMP_BITS;
    wire [4:0] last_idx = word_bits - 5'h01;
    // companded words sit in the top byte so the msb always leaves from bit 15
    wire [15:0] tx_load = linear_mode ? tx_sample : {tx_sample[7:0], 8'h00};

    // receive sampling point
    wire rx_start = rx_fs_rise;
    wire rx_open = rx_start | rx_active_reg;
    wire rx_take = fixed_rate_mode ? rx_open : (rx_active_reg & rx_bclk_fall);
    wire [4:0] rx_cnt_base = rx_start ? 5'h00 : rx_cnt_reg;
    wire [15:0] rx_shift_in = {rx_shift_reg[14:0], serial_in};
    wire rx_last = rx_take & (rx_cnt_base == last_idx);
    wire [15:0] rx_word = linear_mode ? rx_shift_in : {8'h00, rx_shift_in[7:0]};
    wire rx_abort = ~fixed_rate_mode & rx_fs_fall & ~rx_last;

    // two flip-flop synchronisers for every link input
    always_ff @(posedge link.mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg <= 4'h0;
        end else begin
            sync1_reg <= {link.rx_serial, link.rx_bit_clock, link.tx_bit_clock,
                          link.rx_frame_sync, link.tx_frame_sync};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg[3:0];
        end
    end

    // transmit sequencer
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next = tx_cnt_reg;
        if (fixed_rate_mode) begin
            case (tx_state_reg)
                codec_pkg::TX_IDLE: begin
                    if (tx_fs_rise) begin
                        tx_state_next = codec_pkg::TX_SHIFT;
                        tx_shift_next = tx_load;
                        tx_cnt_next = 5'h00;
                    end
                end
                codec_pkg::TX_SHIFT: begin
                    if (tx_cnt_reg == last_idx) begin
                        tx_state_next = codec_pkg::TX_IDLE;
                    end else begin
                        tx_shift_next = {tx_shift_reg[14:0], 1'b0};
                        tx_cnt_next = tx_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    tx_state_next = codec_pkg::TX_IDLE;
                end
            endcase
        end else begin
            if (tx_fs_rise) begin
                tx_state_next = codec_pkg::TX_SHIFT;
                tx_shift_next = tx_load;
                tx_cnt_next = 5'h00;
            end else if (tx_fs_fall) begin
                tx_state_next = codec_pkg::TX_IDLE;
            end else begin
                case (tx_state_reg)
                    codec_pkg::TX_SHIFT: begin
                        if (tx_bclk_rise) begin
                            tx_shift_next = {tx_shift_reg[14:0], 1'b0};
                            tx_cnt_next = tx_cnt_reg + 5'h01;
                            if (tx_cnt_reg + 5'h01 == last_idx) begin
                                tx_state_next = codec_pkg::TX_HOLD;
                            end
                        end
                    end
                    codec_pkg::TX_HOLD: begin
                        tx_state_next = codec_pkg::TX_HOLD; // later bit clock rises ignored: last bit held until sync fall
                    end
                    default: begin
                        tx_state_next = codec_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    // transmit registers and pin enables
    always_ff @(posedge link.mclk or negedge nrst) begin
        if (!nrst) begin
            tx_state_reg <= codec_pkg::TX_IDLE;
            tx_shift_reg <= 16'h0000;
            tx_cnt_reg <= 5'h00;
            tx_oe_reg <= 1'b0;
            slot_oe_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_oe_reg <= (tx_state_next != codec_pkg::TX_IDLE);
            slot_oe_reg <= fixed_rate_mode & (tx_state_next == codec_pkg::TX_SHIFT);
        end
    end

    // receive shifter
    always_ff @(posedge link.mclk or negedge nrst) begin
        if (!nrst) begin
            rx_shift_reg <= 16'h0000;
            rx_cnt_reg <= 5'h00;
            rx_active_reg <= 1'b0;
        end else begin
            if (rx_take) begin
                rx_shift_reg <= rx_shift_in;
                rx_cnt_reg <= rx_cnt_base + 5'h01;
            end else if (rx_start) begin
                rx_cnt_reg <= 5'h00;
            end
            if (rx_last || rx_abort) begin
                rx_active_reg <= 1'b0;
            end else if (rx_open) begin
                rx_active_reg <= 1'b1;
            end
        end
    end

    // completed receive word and volume field
    always_ff @(posedge link.mclk or negedge nrst) begin
        if (!nrst) begin
            rx_sample_reg <= 16'h0000;
            rx_valid_reg <= 1'b0;
            volume_reg <= codec_pkg::VOL_MAX;
        end else begin
            rx_valid_reg <= rx_last;
            if (rx_last) begin
                rx_sample_reg <= rx_word;
            end
            if (rx_last && linear_mode) begin
                volume_reg <= rx_word[codec_pkg::VOL_LSB +: codec_pkg::VOL_W];
            end
        end
    end

    // sample rate taken from the transmit sync repetition
    always_ff @(posedge link.mclk or negedge nrst) begin
        if (!nrst) begin
            period_cnt_reg <= 8'h00;
            period_reg <= 8'h00;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= tx_fs_rise;
            if (tx_fs_rise) begin
                period_reg <= period_cnt_reg;
                period_cnt_reg <= 8'h01;
            end else if (period_cnt_reg != codec_pkg::PERIOD_MAX) begin
                period_cnt_reg <= period_cnt_reg + 8'h01;
            end
        end
    end

    // link outputs
    assign link.tx_serial_o = tx_shift_reg[codec_pkg::MSB_IDX];
    assign link.tx_serial_oe = tx_oe_reg;
    assign link.slot_o = 1'b0; // open drain: only ever pulls low
    assign link.slot_oe = slot_oe_reg;

    // user side outputs
    assign rx_sample = rx_sample_reg;
    assign rx_sample_valid = rx_valid_reg;
    assign volume_attenuation_field = volume_reg;
    assign frame_strobe = strobe_reg;
    assign frame_period = period_reg;
endmodule

// >>> logic/codec_host.sv
// host end of the codec link plus its transmit word fifo
// assumes clk at 20 MHz; makes the master clock by dividing clk by two
`timescale 1ns/1ps
module codec_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic in_ready_reg;
    logic out_valid_reg;

    // handshakes and next fill level
    wire push = in_valid & in_ready_reg;
    wire pop = out_valid_reg & out_ready;
    wire [AW:0] count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    wire [AW-1:0] wr_ptr_inc = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    wire [AW-1:0] rd_ptr_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and registered flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'b0;
            out_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_inc;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_inc;
            end
            count_reg <= count_next;
            in_ready_reg <= (count_next != FULL);
            out_valid_reg <= (count_next != '0);
        end
    end

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data = mem_reg[rd_ptr_reg];
endmodule

module codec_host (
    codec_link_if.host link,
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic linear_mode,
    input wire logic fixed_rate_mode,
    output logic [15:0] rx_data,
    output logic rx_valid
);
    logic [8:0] phase_reg;
    logic mclk_reg;
    logic fs_reg;
    logic bclk_reg;
    logic din_reg;
    logic [15:0] frame_word_reg;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [15:0] rx_shift_reg;
    logic [4:0] rx_cnt_reg;
    logic [15:0] rx_data_reg;
    logic rx_valid_reg;
    logic [15:0] fifo_data;
    logic fifo_valid;

    // frame position: master clock slot and variable rate bit
    wire [8:0] phase_next = (phase_reg == codec_pkg::PHASE_LAST) ? codec_pkg::PHASE_FIRST : phase_reg + 9'h001;
    wire [4:0] word_bits = linear_mode ? codec_pkg::LIN_BITS : codec_pkg::COMP_BITS;
    wire [7:0] slot_next = phase_next[8:1];
    wire [4:0] vbit_next = phase_next[8:4];
    wire [4:0] vbit_now = phase_reg[8:4];
    wire [4:0] idx_next = fixed_rate_mode ? slot_next[4:0] : vbit_next;
    wire in_word_next = fixed_rate_mode ? (slot_next < {3'h0, word_bits}) : (vbit_next < word_bits);
    wire fs_next = fixed_rate_mode ? (slot_next == 8'h00) : in_word_next;
    wire bclk_next = ~fixed_rate_mode & in_word_next & (phase_next[3:0] < codec_pkg::VDR_HIGH_END);
    wire din_next = in_word_next & frame_word_reg[codec_pkg::MSB_IDX - idx_next[3:0]];
    wire load_word = (phase_next == codec_pkg::PHASE_LAST);

    // receive sampling from the synchronised device output
    wire take_fixed = fixed_rate_mode & mclk_reg & ~sync2_reg[1];
    wire take_vdr = ~fixed_rate_mode & (vbit_now < word_bits) & (phase_reg[3:0] == codec_pkg::VDR_SAMPLE);
    wire take = take_fixed | take_vdr;
    wire [15:0] rx_shift_in = {rx_shift_reg[14:0], sync2_reg[0]};
    wire rx_last = take & (rx_cnt_reg == word_bits - 5'h01);
    wire rx_clear = fixed_rate_mode ? sync2_reg[1] : (vbit_now >= word_bits);

    codec_fifo #(
        .WIDTH(codec_pkg::WORD_W),
        .DEPTH(codec_pkg::FIFO_DEPTH)
    ) tx_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(load_word)
    );

    // master clock divider and link drive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // start on the last phase so frame 0 opens while the master clock stays low, never beside a rise
            phase_reg <= codec_pkg::PHASE_LAST;
            mclk_reg <= 1'b0;
            fs_reg <= 1'b0;
            bclk_reg <= 1'b0;
            din_reg <= 1'b0;
            frame_word_reg <= 16'h0000;
        end else begin
            phase_reg <= phase_next;
            mclk_reg <= phase_next[0];
            fs_reg <= fs_next;
            bclk_reg <= bclk_next;
            din_reg <= din_next;
            if (load_word) begin
                frame_word_reg <= fifo_valid ? (linear_mode ? fifo_data : {fifo_data[7:0], 8'h00}) : 16'h0000;
            end
        end
    end

    // synchronise serial line and slot indicator, then shift in
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 2'h3;
            sync2_reg <= 2'h3;
            rx_shift_reg <= 16'h0000;
            rx_cnt_reg <= 5'h00;
            rx_data_reg <= 16'h0000;
            rx_valid_reg <= 1'b0;
        end else begin
            sync1_reg <= {link.tx_slot_indicator_n, link.tx_serial};
            sync2_reg <= sync1_reg;
            rx_valid_reg <= rx_last;
            if (rx_last) begin
                rx_cnt_reg <= 5'h00;
                rx_data_reg <= linear_mode ? rx_shift_in : {8'h00, rx_shift_in[7:0]};
            end else if (take) begin
                rx_shift_reg <= rx_shift_in;
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
            end else if (rx_clear) begin
                rx_cnt_reg <= 5'h00;
            end
        end
    end

    assign link.mclk = mclk_reg;
    assign link.tx_frame_sync = fs_reg;
    assign link.rx_frame_sync = fs_reg;
    assign link.tx_bit_clock = bclk_reg;
    assign link.rx_bit_clock = bclk_reg;
    assign link.rx_serial = din_reg;
    assign rx_data = rx_data_reg;
    assign rx_valid = rx_valid_reg;
endmodule

// >>> test/codec_link_props.sv
// concurrent checks on the device side of the codec serial link, master clock domain
// assumes the link signals, the device's mode inputs and its transmit word as plain inputs
`timescale 1ns/1ps
module codec_link_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic tx_frame_sync,
    input wire logic tx_bit_clock,
    input wire logic tx_serial_o,
    input wire logic tx_serial_oe,
    input wire logic slot_oe,
    input wire logic linear_mode,
    input wire logic fixed_rate_mode,
    input wire logic [15:0] tx_sample
);
    logic [4:0] oe_run_reg;
    logic [4:0] oe_run_next;
    logic [2:0] settle_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // expected word length and first bit for the selected coding
    wire [4:0] word_bits = linear_mode ? codec_pkg::LIN_BITS : codec_pkg::COMP_BITS;
    wire first_bit = linear_mode ? tx_sample[15] : tx_sample[7];
    assign oe_run_next = tx_serial_oe ? oe_run_reg + 5'h01 : 5'h00;
    // master clocks the output has been driven in this word
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oe_run_reg <= 5'h00;
        end else begin
            oe_run_reg <= oe_run_next;
        end
    end
    // master clock rises since reset, so no history reaches back across a reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            settle_reg <= 3'h0;
        end else if (settle_reg != 3'h7) begin
            settle_reg <= settle_reg + 3'h1;
        end
    end
    sequence s_sync_rise;
        $rose(tx_frame_sync);
    endsequence
    sequence s_oe_on;
        ##[2:4] $rose(tx_serial_oe);
    endsequence
    property p_tx_start;
        s_sync_rise |-> s_oe_on;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("output not driven after sync rise");
    property p_slot_fixed;
        fixed_rate_mode |-> slot_oe == tx_serial_oe;
    endproperty
    a_slot_fixed: assert property (p_slot_fixed) else $error("slot indicator not aligned to output");
    property p_word_len;
        fixed_rate_mode && $fell(tx_serial_oe) && oe_run_reg != 5'h00 |-> oe_run_reg == word_bits;
    endproperty
    a_word_len: assert property (p_word_len) else $error("wrong slot count before release");
    property p_msb_first;
        $rose(tx_serial_oe) |-> tx_serial_o == first_bit;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first slot not the top bit");
    property p_lsb_last;
        $fell(tx_serial_oe) && oe_run_reg != 5'h00 |-> $past(tx_serial_o) == tx_sample[0];
    endproperty
    a_lsb_last: assert property (p_lsb_last) else $error("final slot not the bottom bit");
    property p_var_hold;
        !fixed_rate_mode && tx_serial_oe && $fell(tx_bit_clock) |=> $stable(tx_serial_o) [*3];
    endproperty
    a_var_hold: assert property (p_var_hold) else $error("output moved without bit clock rise");
    property p_var_release;
        !fixed_rate_mode && $fell(tx_frame_sync) |-> ##[2:4] !tx_serial_oe;
    endproperty
    a_var_release: assert property (p_var_release) else $error("output kept after sync fall");
    property p_var_oe_holds;
        !fixed_rate_mode && settle_reg == 3'h7 && tx_frame_sync && $past(tx_frame_sync, 4) |-> tx_serial_oe;
    endproperty
    a_var_oe_holds: assert property (p_var_oe_holds) else $error("output released while sync high");
endmodule

// >>> test/testbench.sv
// self-checking bench joining the host end and the codec device end over one link
// assumes the design files under logic/ and the link checker are compiled first
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic lin;
        logic fix;
        logic [15:0] host_word;
        logic [15:0] dev_word;
        logic [15:0] rx_exp;
        logic [15:0] tx_exp;
        logic [2:0] vol_exp;
    } row_t;
    localparam int LIMIT = 20000;
    row_t rows [4] = '{
        '{1'h1, 1'h1, 16'ha5c0, 16'h8001, 16'ha5c0, 16'h8001, 3'h0},
        '{1'h0, 1'h1, 16'h7e81, 16'h12c5, 16'h0081, 16'h00c5, 3'h0},
        '{1'h1, 1'h0, 16'h3c07, 16'hfffe, 16'h3c07, 16'hfffe, 3'h7},
        '{1'h0, 1'h0, 16'hff80, 16'h5501, 16'h0080, 16'h0001, 3'h0}
    };
    logic clk = 1'h0;
    logic nrst = 1'h1;
    logic [15:0] tx_data = 16'h0000;
    logic tx_valid = 1'h0;
    logic linear_mode = 1'h0;
    logic fixed_rate_mode = 1'h0;
    logic [15:0] tx_sample = 16'h0000;
    logic tx_ready;
    logic [15:0] rx_data;
    logic rx_valid;
    logic [15:0] rx_sample;
    logic rx_sample_valid;
    logic [2:0] volume_attenuation_field;
    logic frame_strobe;
    logic [7:0] frame_period;
    logic [15:0] dev_last = 16'h0000;
    logic [2:0] vol_last = 3'h0;
    logic [15:0] host_last = 16'h0000;
    logic [15:0] wire_word = 16'h0000;
    logic [15:0] exp_tx = 16'h0000;
    logic [4:0] exp_bits = 5'h00;
    int dev_n = 0;
    int host_n = 0;
    int wire_n = 0;
    int strobe_n = 0;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    codec_link_if link ();
    codec_host codec_host_i (.link(link.host), .clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .linear_mode(linear_mode), .fixed_rate_mode(fixed_rate_mode), .rx_data(rx_data),
        .rx_valid(rx_valid));
    codec_device codec_device_i (.link(link.device), .nrst(nrst), .tx_sample(tx_sample), .linear_mode(linear_mode),
        .fixed_rate_mode(fixed_rate_mode), .rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid),
        .volume_attenuation_field(volume_attenuation_field), .frame_strobe(frame_strobe),
        .frame_period(frame_period));
    codec_link_props codec_link_props_i (.mclk(link.mclk), .nrst(nrst), .tx_frame_sync(link.tx_frame_sync),
        .tx_bit_clock(link.tx_bit_clock), .tx_serial_o(link.tx_serial_o), .tx_serial_oe(link.tx_serial_oe),
        .slot_oe(link.slot_oe), .linear_mode(linear_mode), .fixed_rate_mode(fixed_rate_mode),
        .tx_sample(tx_sample));

    // 20 MHz clock and a cycle ceiling against hangs
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // received words taken where they have settled
    always @(negedge link.mclk) begin
        if (rx_sample_valid === 1'h1) begin
            dev_n++;
            dev_last = rx_sample;
            vol_last = volume_attenuation_field;
        end
        if (frame_strobe === 1'h1) begin
            strobe_n++;
        end
    end
    always @(negedge clk) begin
        if (rx_valid === 1'h1) begin
            host_n++;
            host_last = rx_data;
        end
    end

    // transmit word rebuilt from the line, per master clock or per bit clock
    always @(negedge link.mclk) begin
        if (fixed_rate_mode && link.tx_serial_oe === 1'h1) begin
            wire_word = {wire_word[14:0], link.tx_serial};
            wire_n++;
        end
    end
    always @(negedge link.tx_bit_clock) begin
        if (!fixed_rate_mode && link.tx_serial_oe === 1'h1) begin
            wire_word = {wire_word[14:0], link.tx_serial};
            wire_n++;
        end
    end
    always @(negedge link.tx_serial_oe) begin
        if (nrst === 1'h1) begin
            check_val("wire word", exp_tx, wire_word);
            check_val("wire bits", 16'(exp_bits), 16'(wire_n));
        end
        wire_word = 16'h0000;
        wire_n = 0;
    end

    // one mode per row: reset, fill the fifo until refused, exchange words, drain
    task automatic run_row(input row_t r);
        int taken;
        int k;
        taken = 0;
        k = 0;
        @(posedge clk);
        nrst <= 1'h0;
        linear_mode <= r.lin;
        fixed_rate_mode <= r.fix;
        tx_sample <= r.dev_word;
        exp_tx = r.tx_exp;
        exp_bits = r.lin ? 5'h10 : 5'h08;
        repeat (6) @(posedge clk);
        check_val("idle line", 16'h0001, {15'h0000, link.tx_serial});
        check_val("idle slot", 16'h0001, {15'h0000, link.tx_slot_indicator_n});
        dev_n = 0;
        host_n = 0;
        strobe_n = 0;
        nrst <= 1'h1;
        repeat (2) @(posedge clk);
        tx_data <= r.host_word;
        tx_valid <= 1'h1;
        while (taken < 8) begin
            @(negedge clk);
            if (tx_ready !== 1'h1) begin
                break;
            end
            taken++;
            @(posedge clk);
        end
        @(posedge clk);
        tx_valid <= 1'h0;
        check_val("words taken", 16'(codec_pkg::FIFO_DEPTH), 16'(taken));
        while ((dev_n < 2 || host_n < 2) && k < 2000) begin
            @(negedge clk);
            k++;
        end
        // a wait that runs out is a mismatch
        if (k == 2000) begin
            failures++;
            tally_and_finish();
        end
        check_val("device word", r.rx_exp, dev_last);
        check_val("volume", 16'(r.vol_exp), 16'(vol_last));
        check_val("host word", r.tx_exp, r.lin ? host_last : {8'h00, host_last[7:0]});
        check_val("frame period", 16'h0090, {8'h00, frame_period});
        k = 0;
        while (dev_n < 6 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k == 3000) begin
            failures++;
            tally_and_finish();
        end
        check_val("drained word", 16'h0000, dev_last);
        check_val("frame strobes", 16'h0006, 16'(strobe_n));
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            run_row(rows[i]);
        end
        // awkward case: a reset in mid-word releases the serial line; in variable rate the slot line is already released
        wait (link.tx_serial_oe === 1'h1);
        @(posedge clk);
        nrst <= 1'h0;
        @(negedge clk);
        check_val("reset line", 16'h0001, {15'h0000, link.tx_serial});
        check_val("reset slot", 16'h0001, {15'h0000, link.tx_slot_indicator_n});
        tally_and_finish();
    end
endmodule
